// *** hdl/ftr_regs.sv ***
`default_nettype none
`include "ftr_cfg.svh"
module ftr_regs (
  input  wire logic        clk,                  // 200 MHz system clock
  input  wire logic        rst_n,                // async reset, active low
  input  wire logic        ce,                   // clock enable, freezes all state
  input  wire logic        psel,                 // apb select
  input  wire logic        penable,              // apb enable
  input  wire logic        pwrite,               // apb direction
  input  wire logic [11:0] paddr,                // apb byte address
  input  wire logic [31:0] pwdata,               // apb write data
  output logic      [31:0] prdata,               // apb read data
  output logic             pready,               // apb ready
  output logic             pslverr,              // apb error
  input  wire logic [3:0]  drv_ratio_in,         // driver transient ratio from tx
  input  wire logic [2:0]  drv_timing_in,        // driver timing code from tx
  input  wire logic [3:0]  adjust_code_in,       // adjust-regulators result
  output logic      [2:0]  peer_off_level,       // peer deactivation threshold code
  output logic      [3:0]  collision_off_level,  // collision deactivation code
  output logic             collision_fine_range, // collision code in fine range
  output logic             reg_manual_mode,      // regulators set from written code
  output logic      [3:0]  reg_code,             // regulated voltage code in use
  output logic      [2:0]  supply_sel,           // measure power supply source
  output logic             supply_valid,         // supply code not reserved
  output logic      [2:0]  drv_speed_class       // decoded driver speed class
);

  ftr_bus_if bus ();

  ftr_apb_port u_port (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus.port)
  );

  logic [7:0] field_off_q, field_off_d;
  logic [7:0] reg_ctrl_q, reg_ctrl_d;
  logic [7:0] drv_disp_q, drv_disp_d;
  logic       sel_field_off, sel_reg_ctrl, sel_drv_disp;

  always_comb
  begin
    sel_field_off = !bus.space_b && (bus.index == `FTR_IDX_FIELD_OFF);
    sel_reg_ctrl  = !bus.space_b && (bus.index == `FTR_IDX_REG_CTRL);
    sel_drv_disp  = bus.space_b && (bus.index == `FTR_IDX_DRV_TIMING);
    bus.hit       = sel_field_off || sel_reg_ctrl || sel_drv_disp;
    bus.rdata     = 8'h00;
    if (sel_field_off)
    begin
      bus.rdata = field_off_q;
    end
    else if (sel_reg_ctrl)
    begin
      bus.rdata = reg_ctrl_q;
    end
    else if (sel_drv_disp)
    begin
      bus.rdata = drv_disp_q;
    end
  end

  // threshold register: bit 7 is unused and stays zero
  always_comb
  begin
    field_off_d = field_off_q;
    if (bus.wr_en && sel_field_off)
    begin
      field_off_d = {1'b0, bus.wdata[6:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      field_off_q <= `FTR_RST_FIELD_OFF;
    end
    else if (ce)
    begin
      field_off_q <= field_off_d;
    end
  end

  // reserved supply codes are kept so software reads back what it wrote
  always_comb
  begin
    reg_ctrl_d = reg_ctrl_q;
    if (bus.wr_en && sel_reg_ctrl)
    begin
      reg_ctrl_d = bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_ctrl_q <= `FTR_RST_REG_CTRL;
    end
    else if (ce)
    begin
      reg_ctrl_q <= reg_ctrl_d;
    end
  end

  // display follows the driver every cycle; a host write has no path here
  always_comb
  begin
    drv_disp_d = {drv_ratio_in, 1'b0, drv_timing_in};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drv_disp_q <= 8'h00;
    end
    else if (ce)
    begin
      drv_disp_q <= drv_disp_d;
    end
  end

  logic [3:0]             dec_code;
  ftr_pkg::ftr_supply_t   dec_supply;
  logic                   dec_valid;
  ftr_pkg::ftr_speed_t    dec_speed;

  ftr_decode u_decode (
    .reg_ctrl     (reg_ctrl_q),
    .adjust_code  (adjust_code_in),
    .speed_raw    (drv_disp_q[`FTR_SPEED_MSB:`FTR_SPEED_LSB]),
    .reg_code     (dec_code),
    .supply_sel   (dec_supply),
    .supply_valid (dec_valid),
    .speed_class  (dec_speed)
  );

  // outputs registered so the analog side sees glitch-free codes
  logic [2:0] peer_q, peer_d;
  logic [3:0] coll_q, coll_d;
  logic       fine_q, fine_d;
  logic       manual_q, manual_d;
  logic [3:0] code_q, code_d;
  logic [2:0] supply_q, supply_d;
  logic       valid_q, valid_d;
  logic [2:0] speed_q, speed_d;

  // threshold codes towards the field detector
  always_comb
  begin
    peer_d = field_off_q[`FTR_PEER_MSB:`FTR_PEER_LSB];
    coll_d = field_off_q[`FTR_COLL_MSB:`FTR_COLL_LSB];
    // range bit shared with the field-on register; software keeps them equal
    fine_d = field_off_q[`FTR_COLL_MSB];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peer_q <= 3'h3;
      coll_q <= 4'h3;
      fine_q <= 1'b0;
    end
    else if (ce)
    begin
      peer_q <= peer_d;
      coll_q <= coll_d;
      fine_q <= fine_d;
    end
  end

  // regulator and supply measurement selects
  always_comb
  begin
    manual_d = reg_ctrl_q[`FTR_MANUAL_BIT];
    code_d   = dec_code;
    supply_d = dec_supply;
    valid_d  = dec_valid;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      manual_q <= 1'b0;
      code_q   <= 4'h0;
      supply_q <= 3'h0;
      valid_q  <= 1'b1;
    end
    else if (ce)
    begin
      manual_q <= manual_d;
      code_q   <= code_d;
      supply_q <= supply_d;
      valid_q  <= valid_d;
    end
  end

  // decoded driver speed, two cycles behind the driver inputs
  always_comb
  begin
    speed_d = dec_speed;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_q <= 3'h0;
    end
    else if (ce)
    begin
      speed_q <= speed_d;
    end
  end

  assign peer_off_level       = peer_q;
  assign collision_off_level  = coll_q;
  assign collision_fine_range = fine_q;
  assign reg_manual_mode      = manual_q;
  assign reg_code             = code_q;
  assign supply_sel           = supply_q;
  assign supply_valid         = valid_q;
  assign drv_speed_class      = speed_q;

endmodule
`default_nettype wire

// *** hdl/ftr_cfg.svh ***
`ifndef FTR_CFG_SVH
`define FTR_CFG_SVH

// register indices; byte address = space base + 4 * index
`define FTR_IDX_FIELD_OFF    8'h2B
`define FTR_IDX_DRV_TIMING   8'h2B
`define FTR_IDX_REG_CTRL     8'h2C
`define FTR_SPACE_B_BIT      10
`define FTR_SPACE_A_BASE     12'h000
`define FTR_SPACE_B_BASE     12'h400

// reset values
`define FTR_RST_FIELD_OFF    8'h33
`define FTR_RST_REG_CTRL     8'h00

// field positions, field_off_threshold
`define FTR_PEER_MSB         6
`define FTR_PEER_LSB         4
`define FTR_COLL_MSB         3
`define FTR_COLL_LSB         0

// field positions, driver_timing_display
`define FTR_RATIO_MSB        7
`define FTR_RATIO_LSB        4
`define FTR_SPEED_MSB        2
`define FTR_SPEED_LSB        0

// field positions, regulator_voltage_control
`define FTR_MANUAL_BIT       7
`define FTR_EXT_MSB          6
`define FTR_EXT_LSB          3
`define FTR_MSEL_MSB         2
`define FTR_MSEL_LSB         0

`endif

// *** hdl/ftr_pkg.sv ***
`default_nettype none
package ftr_pkg;

  typedef enum logic [2:0] {
    FTR_SPEED_SLOW     = 3'b000,
    FTR_SPEED_MED_SLOW = 3'b001,
    FTR_SPEED_NOMINAL  = 3'b010,
    FTR_SPEED_MED_FAST = 3'b011,
    FTR_SPEED_FAST     = 3'b100
  } ftr_speed_t;

  typedef enum logic [2:0] {
    FTR_SUP_MAIN    = 3'b000,
    FTR_SUP_ANALOG  = 3'b001,
    FTR_SUP_DIGITAL = 3'b010,
    FTR_SUP_RF      = 3'b011,
    FTR_SUP_AM      = 3'b100
  } ftr_supply_t;

endpackage
`default_nettype wire

// *** hdl/ftr_bus_if.sv ***
`default_nettype none
interface ftr_bus_if;
  logic       wr_en;
  logic       space_b;
  logic [7:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hit;

  modport port (output wr_en, output space_b, output index, output wdata,
                input rdata, input hit);
  modport bank (input wr_en, input space_b, input index, input wdata,
                output rdata, output hit);
endinterface
`default_nettype wire

// *** hdl/ftr_apb_port.sv ***
`default_nettype none
`include "ftr_cfg.svh"
module ftr_apb_port (
  input  wire logic        clk,      // system clock
  input  wire logic        rst_n,    // async reset, active low
  input  wire logic        ce,       // clock enable
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  ftr_bus_if.port          bus       // register bank access
);

  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        setup;
  logic        ok;

  assign bus.space_b = paddr[`FTR_SPACE_B_BIT];
  assign bus.index   = paddr[9:2];
  assign bus.wdata   = pwdata[7:0];
  // only word aligned addresses inside the two spaces are mapped
  assign ok          = bus.hit && (paddr[1:0] == 2'b00) && !paddr[11];
  assign setup       = psel && !penable;
  assign bus.wr_en   = ce && psel && penable && pwrite && pready_q && ok;

  // answer is fixed: one access cycle, ready in the cycle after setup
  always_comb
  begin
    pready_d  = setup;
    pslverr_d = setup && !ok;
    prdata_d  = prdata_q;
    if (setup)
    begin
      prdata_d = {24'h00_0000, (ok && !pwrite) ? bus.rdata : 8'h00};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule
`default_nettype wire

// *** hdl/ftr_decode.sv ***
`default_nettype none
`include "ftr_cfg.svh"
module ftr_decode (
  input  wire logic [7:0]          reg_ctrl,       // regulator control contents
  input  wire logic [3:0]          adjust_code,    // automatic adjust result
  input  wire logic [2:0]          speed_raw,      // raw driver timing code
  output logic      [3:0]          reg_code,       // regulated voltage code in use
  output ftr_pkg::ftr_supply_t     supply_sel,     // measured supply
  output logic                     supply_valid,   // supply code not reserved
  output ftr_pkg::ftr_speed_t      speed_class     // driver speed class
);

  always_comb
  begin
    // manual mode picks the written code, else the adjust result
    reg_code = reg_ctrl[`FTR_MANUAL_BIT] ? reg_ctrl[`FTR_EXT_MSB:`FTR_EXT_LSB]
                                         : adjust_code;
    supply_valid = (reg_ctrl[`FTR_MSEL_MSB:`FTR_MSEL_LSB] <= 3'h4);
    // reserved codes fall back to the main supply so the mux never sees them
    supply_sel = supply_valid
      ? ftr_pkg::ftr_supply_t'(reg_ctrl[`FTR_MSEL_MSB:`FTR_MSEL_LSB])
      : ftr_pkg::FTR_SUP_MAIN;
    // any code with the top bit set is fast
    speed_class = speed_raw[2] ? ftr_pkg::FTR_SPEED_FAST
                               : ftr_pkg::ftr_speed_t'(speed_raw);
  end

endmodule
`default_nettype wire

// *** tb/ftr_regs_sva.sv ***
`default_nettype none
module ftr_regs_sva (
  input wire logic        clk,                  // clock
  input wire logic        rst_n,                // reset
  input wire logic        ce,                   // enable
  input wire logic        psel,                 // select
  input wire logic        penable,              // enable
  input wire logic        pwrite,               // direction
  input wire logic [11:0] paddr,                // address
  input wire logic [31:0] pwdata,               // wdata
  input wire logic [31:0] prdata,               // rdata
  input wire logic        pready,               // ready
  input wire logic        pslverr,              // error
  input wire logic [2:0]  drv_timing_in,        // timing
  input wire logic [3:0]  adjust_code_in,       // adjust
  input wire logic [2:0]  peer_off_level,       // peer
  input wire logic [3:0]  collision_off_level,  // collision
  input wire logic        collision_fine_range, // fine
  input wire logic        reg_manual_mode,      // manual
  input wire logic [3:0]  reg_code,             // code
  input wire logic [2:0]  supply_sel,           // supply
  input wire logic        supply_valid,         // valid
  input wire logic [2:0]  drv_speed_class       // speed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       acc;
  logic [7:0] wb;
  assign acc = psel && penable && pready && pwrite && ce;
  assign wb = pwdata[7:0];
  AST_READY: assert property (psel && !penable && ce |=> pready)
    else $error("setup not answered");
  AST_PULSE: assert property (pready && ce |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("unaligned access not refused");
  AST_HI: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_FIELD: assert property (acc && paddr == 12'h0ac |-> ##2
    {1'b0, peer_off_level, collision_off_level} == ($past(wb, 2) & 8'h7f))
    else $error("threshold outputs wrong");
  AST_FINE: assert property (collision_fine_range == collision_off_level[3])
    else $error("fine range mismatch");
  AST_CTRL: assert property (acc && paddr == 12'h0b0 |-> ##2
    reg_manual_mode == ($past(wb, 2) > 8'h7f) && supply_valid == (($past(wb, 2) & 8'h07) < 8'h05))
    else $error("regulator control outputs wrong");
  // outputs only move on enabled edges, so the look-back needs ce on those edges
  AST_AUTO: assert property (!reg_manual_mode && $past(ce) |->
    reg_code == $past(adjust_code_in))
    else $error("auto code not followed");
  AST_RSV: assert property (!supply_valid |-> supply_sel == 3'h0)
    else $error("reserved supply selected");
  AST_SPEED: assert property ($past(ce) && $past(ce, 2) |-> drv_speed_class ==
    ($past(drv_timing_in, 2) > 3'h3 ? 3'h4 : $past(drv_timing_in, 2)))
    else $error("speed class wrong");
endmodule
`default_nettype wire

// *** tb/field_threshold_regulator_regs_tb_top.sv ***
`default_nettype none
module field_threshold_regulator_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, er, d7;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  drv_ratio_in, adjust_code_in, collision_off_level, reg_code;
  logic [2:0]  drv_timing_in, peer_off_level, supply_sel, drv_speed_class;
  logic        collision_fine_range, reg_manual_mode, supply_valid;
  logic [7:0]  d;
  int          num_errors, n_compared, seed, cyc;
  logic [11:0] bad [4] = '{12'h0b4, 12'h0ad, 12'h8ac, 12'h4b0};
  ftr_regs DUT (.*);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge; answer taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
    chk(er, ee);
  endtask
  function automatic logic [2:0] f_speed(input logic [2:0] t);
    return t[2] ? ftr_pkg::FTR_SPEED_FAST : t;
  endfunction
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    seed = 96516;
    {rst_n, ce, psel, penable, pwrite, paddr, pwdata} = {2'b01, 47'h0};
    {drv_ratio_in, drv_timing_in, adjust_code_in} = 11'h000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({peer_off_level, collision_off_level}, 7'h33);
    chk({collision_fine_range, supply_valid}, 2'b01);
    rdx(12'h0ac, 32'h0000_0033, 1'b0);
    rdx(12'h0b0, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 24; i++)
    begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      // the field-on register lies outside this block, so any range bit agrees
      apb(1'b1, 12'h0ac, {24'h00_0000, d});
      repeat (2) @(negedge clk);
      chk({peer_off_level, collision_off_level}, d[6:0]);
      chk(collision_fine_range, d[3]);
      rdx(12'h0ac, {24'h00_0000, d & 8'h7f}, 1'b0);
    end
    // unmapped writes must be refused and must not reach the threshold register
    foreach (bad[i])
    begin
      apb(1'b1, bad[i], 32'h0000_0000);
      chk(er, 1'b1);
    end
    foreach (bad[i]) rdx(bad[i], 32'h0000_0000, 1'b1);
    rdx(12'h0ac, {24'h00_0000, d & 8'h7f}, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      d = {8'($random(seed))};
      d[2:0] = i[2:0];
      d7 = d[2:0] < 3'h5;
      @(posedge clk);
      adjust_code_in <= 4'($random(seed));
      apb(1'b1, 12'h0b0, {24'h00_0000, d});
      repeat (2) @(negedge clk);
      chk(reg_code, d[7] ? d[6:3] : adjust_code_in);
      chk({reg_manual_mode, supply_valid, supply_sel}, {d[7], d7, d7 ? d[2:0] : 3'h0});
      rdx(12'h0b0, {24'h00_0000, d}, 1'b0);
    end
    for (int t = 0; t < 8; t++)
    begin
      @(posedge clk);
      drv_timing_in <= t[2:0];
      drv_ratio_in <= 4'($random(seed));
      repeat (3) @(negedge clk);
      chk(drv_speed_class, f_speed(t[2:0]));
      apb(1'b1, 12'h4ac, 32'hffff_ffff);
      chk(er, 1'b0);
      rdx(12'h4ac, {24'h00_0000, drv_ratio_in, 1'b0, t[2:0]}, 1'b0);
    end
    // with the clock enable low the display path must hold its last code
    @(posedge clk);
    ce <= 1'b0;
    drv_timing_in <= 3'h0;
    repeat (4) @(negedge clk);
    chk(drv_speed_class, f_speed(3'h7));
    @(posedge clk);
    ce <= 1'b1;
    repeat (3) @(negedge clk);
    chk(drv_speed_class, f_speed(3'h0));
    tally_and_finish();
  end
endmodule
bind ftr_regs ftr_regs_sva u_sva (.*);
`default_nettype wire
